// File: src/bcem_consts.svh
/*
 constants for the boot capture / event mux register bank: offsets, field positions, reset values.
 assumes inclusion by bare name from the package and the design module.
*/
`ifndef BCEM_CONSTS_SVH
`define BCEM_CONSTS_SVH
`define BCEM_OFF_BOOT       12'h000
`define BCEM_OFF_IRQ_SEL    12'h004
`define BCEM_OFF_DMA_SEL    12'h008
`define BCEM_BOOT_GPIO_BIT  8
`define BCEM_BOOT_SRC_HI    7
`define BCEM_BOOT_SRC_LO    6
`define BCEM_BOOT_MEM_HI    3
`define BCEM_BOOT_MEM_LO    0
`define BCEM_IRQ_SEL_W      8
`define BCEM_DMA_SEL_W      3
`define BCEM_IRQ_SEL_RST    8'h00
`define BCEM_DMA_SEL_RST    3'h0
`define BCEM_RESP_OKAY      2'h0
`define BCEM_RESP_SLVERR    2'h2
`endif

// File: src/bcem_pkg.sv
/*
 types for the boot capture / event mux register bank.
 assumes bcem_consts.svh is on the include path.
*/
`include "bcem_consts.svh"
package bcem_pkg;
   // shared-input sources: [0] is the select-0 source, [1] the select-1 source
   typedef struct packed {
      logic [1:0] irq_in_25;
      logic [1:0] irq_in_24;
      logic [1:0] irq_in_19;
      logic [1:0] irq_in_18;
      logic [1:0] irq_in_17;
      logic [1:0] irq_in_14;
      logic [1:0] irq_in_13;
      logic       irq_in_20;
   } bcem_irq_src_t;
   typedef struct packed {
      logic [1:0] evt_9;
      logic [1:0] evt_8;
      logic       evt_26;
   } bcem_dma_src_t;
   typedef struct packed {
      logic in_25;
      logic in_24;
      logic in_20;
      logic in_19;
      logic in_18;
      logic in_17;
      logic in_14;
      logic in_13;
   } bcem_irq_out_t;
   typedef struct packed {
      logic evt_26;
      logic evt_9;
      logic evt_8;
   } bcem_dma_out_t;
   typedef struct packed {
      logic       gpio_pin_zero_at_reset;
      logic [1:0] boot_source_pins;
      logic [3:0] ext_mem_boot_straps;
   } bcem_straps_t;
   typedef enum logic [1:0] {
      BCEM_BOOT_NAND_SPI,
      BCEM_BOOT_ASYNC_MEM,
      BCEM_BOOT_SD,
      BCEM_BOOT_UART
   } bcem_boot_src_t;
endpackage

// File: src/bcem_regs.sv
/*
 boot pin capture and interrupt / dma event source select register bank, AXI4-Lite slave.
 assumes strap pins arrive asynchronously and are stable around reset release; source lines are on clk.
*/
`timescale 1ns/10ps
`include "bcem_consts.svh"
module bcem_regs (
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire logic [11:0]            s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [11:0]            s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire bcem_pkg::bcem_straps_t strap_pins,
   input  wire bcem_pkg::bcem_irq_src_t irq_src,
   input  wire bcem_pkg::bcem_dma_src_t dma_src,
   output bcem_pkg::bcem_irq_out_t     cpu_irq_controller_in,
   output bcem_pkg::bcem_dma_out_t     dma_controller_evt,
   output bcem_pkg::bcem_boot_src_t    boot_mode,
   output logic                        async_mem_bus_8bit,
   output logic [1:0]                  shared_addr_pin_func,
   output logic                        async_mem_addr_wide
);
   // strap synchroniser; first stage read only by the second
   bcem_pkg::bcem_straps_t strap_s1_reg, strap_s2_reg;
   bcem_pkg::bcem_straps_t cap_reg, cap_next;
   logic                   rst_d_reg;
   logic                   cap_pend_reg, cap_pend_next;

   always_ff @(posedge clk) begin
      strap_s1_reg <= strap_pins;
      strap_s2_reg <= strap_s1_reg;
      rst_d_reg    <= sys_rst;
   end

   // straps are latched two cycles after reset release so the synchroniser has
   // flushed; the gpio sample is taken raw, ahead of any debounce
   always_comb begin
      cap_pend_next = cap_pend_reg;
      cap_next      = cap_reg;
      if (sys_rst) begin
         cap_pend_next = 1'b1;
      end else if (cap_pend_reg && !rst_d_reg) begin
         cap_pend_next = 1'b0;
         cap_next      = strap_s2_reg;
      end
   end

   always_ff @(posedge clk) begin
      cap_pend_reg <= cap_pend_next;
      cap_reg      <= cap_next;
   end

   // registers
   logic [`BCEM_IRQ_SEL_W-1:0] irq_sel_reg, irq_sel_next;
   logic [`BCEM_DMA_SEL_W-1:0] dma_sel_reg, dma_sel_next;
   logic [11:0]                awaddr_reg, awaddr_next;
   logic                       aw_have_reg, aw_have_next;
   logic [31:0]                wdata_reg, wdata_next;
   logic                       wstrb0_reg, wstrb0_next;
   logic                       w_have_reg, w_have_next;
   logic                       bvalid_next;
   logic [1:0]                 bresp_next;
   logic                       rvalid_next;
   logic [31:0]                rdata_next;
   logic [1:0]                 rresp_next;
   logic [31:0]                boot_word;

   always_comb begin
      boot_word = 32'h0000_0000;
      boot_word[`BCEM_BOOT_GPIO_BIT] = cap_reg.gpio_pin_zero_at_reset;
      boot_word[`BCEM_BOOT_SRC_HI:`BCEM_BOOT_SRC_LO] = cap_reg.boot_source_pins;
      boot_word[`BCEM_BOOT_MEM_HI:`BCEM_BOOT_MEM_LO] = cap_reg.ext_mem_boot_straps;
   end

   // write path: address and data taken in either order, response after both
   always_comb begin
      awaddr_next  = awaddr_reg;
      aw_have_next = aw_have_reg;
      wdata_next   = wdata_reg;
      wstrb0_next  = wstrb0_reg;
      w_have_next  = w_have_reg;
      bvalid_next  = s_axi_bvalid;
      bresp_next   = s_axi_bresp;
      irq_sel_next = irq_sel_reg;
      dma_sel_next = dma_sel_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         awaddr_next  = s_axi_awaddr;
         aw_have_next = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wdata_next  = s_axi_wdata;
         wstrb0_next = s_axi_wstrb[0];
         w_have_next = 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      if (aw_have_reg && w_have_reg && !s_axi_bvalid) begin
         aw_have_next = 1'b0;
         w_have_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = `BCEM_RESP_OKAY;
         // only byte lane 0 holds select bits; the capture register ignores writes
         unique case ({awaddr_reg[11:2], 2'b00})
            `BCEM_OFF_IRQ_SEL: begin
               if (wstrb0_reg) irq_sel_next = wdata_reg[`BCEM_IRQ_SEL_W-1:0];
            end
            `BCEM_OFF_DMA_SEL: begin
               if (wstrb0_reg) dma_sel_next = wdata_reg[`BCEM_DMA_SEL_W-1:0];
            end
            `BCEM_OFF_BOOT: begin
               bresp_next = `BCEM_RESP_OKAY;
            end
            default: begin
               bresp_next = `BCEM_RESP_SLVERR;
            end
         endcase
      end
   end

   // read path
   always_comb begin
      rvalid_next = s_axi_rvalid;
      rdata_next  = s_axi_rdata;
      rresp_next  = s_axi_rresp;
      if (s_axi_rvalid && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         rresp_next  = `BCEM_RESP_OKAY;
         unique case ({s_axi_araddr[11:2], 2'b00})
            `BCEM_OFF_BOOT:    rdata_next = boot_word;
            `BCEM_OFF_IRQ_SEL: rdata_next = {24'h00_0000, irq_sel_reg};
            `BCEM_OFF_DMA_SEL: rdata_next = {29'h0000_0000, dma_sel_reg};
            default: begin
               rdata_next = 32'h0000_0000;
               rresp_next = `BCEM_RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_sel_reg   <= `BCEM_IRQ_SEL_RST;
         dma_sel_reg   <= `BCEM_DMA_SEL_RST;
         awaddr_reg    <= 12'h000;
         aw_have_reg   <= 1'b0;
         wdata_reg     <= 32'h0000_0000;
         wstrb0_reg    <= 1'b0;
         w_have_reg    <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `BCEM_RESP_OKAY;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `BCEM_RESP_OKAY;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_arready <= 1'b0;
      end else begin
         irq_sel_reg   <= irq_sel_next;
         dma_sel_reg   <= dma_sel_next;
         awaddr_reg    <= awaddr_next;
         aw_have_reg   <= aw_have_next;
         wdata_reg     <= wdata_next;
         wstrb0_reg    <= wstrb0_next;
         w_have_reg    <= w_have_next;
         s_axi_bvalid  <= bvalid_next;
         s_axi_bresp   <= bresp_next;
         s_axi_rvalid  <= rvalid_next;
         s_axi_rdata   <= rdata_next;
         s_axi_rresp   <= rresp_next;
         // ready is a registered one-cycle pulse, so each beat is taken once
         s_axi_awready <= !aw_have_next && s_axi_awvalid && !s_axi_awready;
         s_axi_wready  <= !w_have_next && s_axi_wvalid && !s_axi_wready;
         s_axi_arready <= !rvalid_next && s_axi_arvalid && !s_axi_arready;
      end
   end

   // source muxes: registered so outputs come from flip-flops; this adds one
   // cycle of latency to every routed interrupt and event
   bcem_pkg::bcem_irq_out_t irq_out_next;
   bcem_pkg::bcem_dma_out_t dma_out_next;

   always_comb begin
      irq_out_next.in_20 = irq_sel_reg[7] ? 1'b0 : irq_src.irq_in_20;
      irq_out_next.in_25 = irq_src.irq_in_25[irq_sel_reg[6]];
      irq_out_next.in_24 = irq_src.irq_in_24[irq_sel_reg[5]];
      irq_out_next.in_19 = irq_src.irq_in_19[irq_sel_reg[4]];
      irq_out_next.in_18 = irq_src.irq_in_18[irq_sel_reg[3]];
      irq_out_next.in_17 = irq_src.irq_in_17[irq_sel_reg[2]];
      irq_out_next.in_14 = irq_src.irq_in_14[irq_sel_reg[1]];
      irq_out_next.in_13 = irq_src.irq_in_13[irq_sel_reg[0]];
      dma_out_next.evt_26 = dma_sel_reg[2] ? 1'b0 : dma_src.evt_26;
      dma_out_next.evt_9  = dma_src.evt_9[dma_sel_reg[1]];
      dma_out_next.evt_8  = dma_src.evt_8[dma_sel_reg[0]];
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cpu_irq_controller_in <= '0;
         dma_controller_evt    <= '0;
         boot_mode             <= bcem_pkg::BCEM_BOOT_NAND_SPI;
         async_mem_bus_8bit    <= 1'b0;
         shared_addr_pin_func  <= 2'h0;
         async_mem_addr_wide   <= 1'b0;
      end else begin
         cpu_irq_controller_in <= irq_out_next;
         dma_controller_evt    <= dma_out_next;
         boot_mode             <= bcem_pkg::bcem_boot_src_t'(cap_reg.boot_source_pins);
         async_mem_bus_8bit    <= cap_reg.ext_mem_boot_straps[3];
         shared_addr_pin_func  <= cap_reg.ext_mem_boot_straps[2:1];
         async_mem_addr_wide   <= cap_reg.ext_mem_boot_straps[0];
      end
   end

   // assertions
   chk_irq25_mux: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> cpu_irq_controller_in.in_25 == $past(irq_src.irq_in_25[irq_sel_reg[6]]))
      else $error("irq input 25 mux wrong");
   chk_irq13_mux: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> cpu_irq_controller_in.in_13 == $past(irq_src.irq_in_13[irq_sel_reg[0]]))
      else $error("irq input 13 mux wrong");
   chk_irq20_route: assert property (@(posedge clk) disable iff (sys_rst)
      (!irq_sel_reg[7] && irq_src.irq_in_20) |=> cpu_irq_controller_in.in_20)
      else $error("sleep controller irq not routed");
   chk_dma_event_9_sel_mux: assert property (@(posedge clk) disable iff (sys_rst)
      ##1 dma_controller_evt.evt_9 == $past(dma_src.evt_9[dma_sel_reg[1]]))
      else $error("dma event 9 mux wrong");
   chk_dma_event_26_sel_route: assert property (@(posedge clk) disable iff (sys_rst)
      (!dma_sel_reg[2] && dma_src.evt_26) |=> dma_controller_evt.evt_26)
      else $error("sd receive event not routed");
   chk_sel_write: assert property (@(posedge clk) disable iff (sys_rst)
      (aw_have_reg && w_have_reg && !s_axi_bvalid && wstrb0_reg && awaddr_reg[11:2] == 10'h001)
      |=> irq_sel_reg == $past(wdata_reg[7:0]) && s_axi_bvalid)
      else $error("irq select write not applied");
   chk_sel_reset: assert property (@(posedge clk)
      sys_rst |=> irq_sel_reg == 8'h00 && dma_sel_reg == 3'h0)
      else $error("select bits not reset to zero");
   chk_boot_read: assert property (@(posedge clk) disable iff (sys_rst)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == 10'h000)
      |=> s_axi_rvalid && s_axi_rdata[31:9] == 23'h00_0000 && s_axi_rdata[5:4] == 2'h0
          && s_axi_rdata[3:0] == cap_reg.ext_mem_boot_straps)
      else $error("boot capture read wrong");
   chk_gpio_bit: assert property (@(posedge clk) disable iff (sys_rst)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == 10'h000)
      |=> s_axi_rdata[8] == cap_reg.gpio_pin_zero_at_reset)
      else $error("gpio sample bit wrong");
   chk_read_bound: assert property (@(posedge clk) disable iff (sys_rst)
      (s_axi_arvalid && !s_axi_rvalid) |-> ##[1:3] s_axi_rvalid)
      else $error("read answer late");
   chk_irq24_mux: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> cpu_irq_controller_in.in_24 == $past(irq_src.irq_in_24[irq_sel_reg[5]]))
      else $error("irq input 24 mux wrong");
   chk_irq19_mux: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> cpu_irq_controller_in.in_19 == $past(irq_src.irq_in_19[irq_sel_reg[4]]))
      else $error("irq input 19 mux wrong");
   chk_irq18_mux: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> cpu_irq_controller_in.in_18 == $past(irq_src.irq_in_18[irq_sel_reg[3]]))
      else $error("irq input 18 mux wrong");
   chk_irq17_mux: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> cpu_irq_controller_in.in_17 == $past(irq_src.irq_in_17[irq_sel_reg[2]]))
      else $error("irq input 17 mux wrong");
   chk_irq14_mux: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> cpu_irq_controller_in.in_14 == $past(irq_src.irq_in_14[irq_sel_reg[1]]))
      else $error("irq input 14 mux wrong");
   chk_dma_event_8_sel_mux: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> dma_controller_evt.evt_8 == $past(dma_src.evt_8[dma_sel_reg[0]]))
      else $error("dma event 8 mux wrong");
   chk_irq20_rsvd: assert property (@(posedge clk) disable iff (sys_rst)
      irq_sel_reg[7] |=> !cpu_irq_controller_in.in_20)
      else $error("reserved irq 20 select not low");
   chk_irq20_idle: assert property (@(posedge clk) disable iff (sys_rst)
      (!irq_sel_reg[7] && !irq_src.irq_in_20) |=> !cpu_irq_controller_in.in_20)
      else $error("irq input 20 high without source");
   chk_dma_event_26_sel_rsvd: assert property (@(posedge clk) disable iff (sys_rst)
      dma_sel_reg[2] |=> !dma_controller_evt.evt_26)
      else $error("reserved event 26 select not low");
   chk_dma_event_26_sel_idle: assert property (@(posedge clk) disable iff (sys_rst)
      (!dma_sel_reg[2] && !dma_src.evt_26) |=> !dma_controller_evt.evt_26)
      else $error("event 26 high without source");
   chk_boot_nand: assert property (@(posedge clk) disable iff (sys_rst)
      (cap_reg.boot_source_pins == 2'h0) |=> boot_mode == bcem_pkg::BCEM_BOOT_NAND_SPI)
      else $error("boot mode 0 decode wrong");
   chk_boot_async: assert property (@(posedge clk) disable iff (sys_rst)
      (cap_reg.boot_source_pins == 2'h1) |=> boot_mode == bcem_pkg::BCEM_BOOT_ASYNC_MEM)
      else $error("boot mode 1 decode wrong");
   chk_bus_8bit: assert property (@(posedge clk) disable iff (sys_rst)
      cap_reg.ext_mem_boot_straps[3] |=> async_mem_bus_8bit)
      else $error("8-bit bus not selected");
   chk_bus_16bit: assert property (@(posedge clk) disable iff (sys_rst)
      !cap_reg.ext_mem_boot_straps[3] |=> !async_mem_bus_8bit)
      else $error("16-bit bus not selected");
   chk_addr_pin_gpio: assert property (@(posedge clk) disable iff (sys_rst)
      (cap_reg.ext_mem_boot_straps[2:1] == 2'h2) |=> shared_addr_pin_func == 2'h2)
      else $error("shared pin gpio mode wrong");
   chk_addr_pin_a14: assert property (@(posedge clk) disable iff (sys_rst)
      (cap_reg.ext_mem_boot_straps[2:1] == 2'h1) |=> shared_addr_pin_func == 2'h1)
      else $error("shared pin address mode wrong");
   chk_addr_wide: assert property (@(posedge clk) disable iff (sys_rst)
      cap_reg.ext_mem_boot_straps[0] |=> async_mem_addr_wide)
      else $error("address width not wide");
   chk_addr_narrow: assert property (@(posedge clk) disable iff (sys_rst)
      !cap_reg.ext_mem_boot_straps[0] |=> !async_mem_addr_wide)
      else $error("address width not narrow");
   chk_dma_write: assert property (@(posedge clk) disable iff (sys_rst)
      (aw_have_reg && w_have_reg && !s_axi_bvalid && wstrb0_reg && awaddr_reg[11:2] == 10'h002)
      |=> dma_sel_reg == $past(wdata_reg[2:0]))
      else $error("dma select write not applied");
   chk_boot_ro: assert property (@(posedge clk) disable iff (sys_rst)
      (aw_have_reg && w_have_reg && !s_axi_bvalid && awaddr_reg[11:2] == 10'h000)
      |=> $stable(irq_sel_reg) && $stable(dma_sel_reg))
      else $error("capture write moved a select");
   chk_strb_ignore: assert property (@(posedge clk) disable iff (sys_rst)
      (aw_have_reg && w_have_reg && !s_axi_bvalid && !wstrb0_reg)
      |=> $stable(irq_sel_reg) && $stable(dma_sel_reg))
      else $error("lane 0 off but select moved");
   chk_irq_readback: assert property (@(posedge clk) disable iff (sys_rst)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == 10'h001)
      |=> s_axi_rdata[31:8] == 24'h00_0000 && s_axi_rdata[7:0] == $past(irq_sel_reg))
      else $error("irq select read wrong");
   chk_dma_readback: assert property (@(posedge clk) disable iff (sys_rst)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == 10'h002)
      |=> s_axi_rdata[31:3] == 29'h0000_0000 && s_axi_rdata[2:0] == $past(dma_sel_reg))
      else $error("dma select read wrong");
   chk_src_field: assert property (@(posedge clk) disable iff (sys_rst)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == 10'h000)
      |=> s_axi_rdata[7:6] == cap_reg.boot_source_pins)
      else $error("boot source field read wrong");
   chk_write_bound: assert property (@(posedge clk) disable iff (sys_rst)
      (aw_have_reg && w_have_reg && !s_axi_bvalid) |=> s_axi_bvalid)
      else $error("write answer late");
   chk_bvalid_drop: assert property (@(posedge clk) disable iff (sys_rst)
      (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
      else $error("write answer repeated");
   chk_rvalid_drop: assert property (@(posedge clk) disable iff (sys_rst)
      (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
      else $error("read answer repeated");
   chk_ready_pulse: assert property (@(posedge clk) disable iff (sys_rst)
      s_axi_awready |=> !s_axi_awready)
      else $error("address ready held");

   cov_sel_flip: cover property (@(posedge clk) disable iff (sys_rst) $rose(irq_sel_reg[6]));
   cov_dma_sel: cover property (@(posedge clk) disable iff (sys_rst) $rose(dma_sel_reg[0]));
   cov_bad_addr: cover property (@(posedge clk) disable iff (sys_rst)
      s_axi_rvalid && s_axi_rresp == 2'h2);
   cov_irq20_rsvd: cover property (@(posedge clk) disable iff (sys_rst) irq_sel_reg[7] && irq_src.irq_in_20);
   cov_boot_write: cover property (@(posedge clk) disable iff (sys_rst)
      aw_have_reg && w_have_reg && !s_axi_bvalid && awaddr_reg[11:2] == 10'h000);
endmodule

// File: test/bcem_src_model.sv
/*
 far-side source model: drives the shared interrupt and dma event source lines.
 assumes one clock; lines change just after each rising edge, a new pattern every cycle.
*/
`timescale 1ns/10ps
module bcem_src_model (
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   output bcem_pkg::bcem_irq_src_t      irq_src,
   output bcem_pkg::bcem_dma_src_t      dma_src
);
   logic [19:0] pat_reg;
   // lfsr so every line toggles often; a stuck mux leg shows up fast
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pat_reg <= 20'h5a3c1;
      end else begin
         pat_reg <= {pat_reg[18:0], pat_reg[19] ^ pat_reg[16]};
      end
   end
   assign irq_src = bcem_pkg::bcem_irq_src_t'(pat_reg[19:5]);
   assign dma_src = bcem_pkg::bcem_dma_src_t'(pat_reg[4:0]);
endmodule

// File: test/tb_top.sv
/*
 self-checking bench for the boot capture / event mux register bank.
 assumes an AXI4-Lite slave with registered ready pulses and the source model beside it.
*/
`timescale 1ns/10ps
`include "bcem_consts.svh"
module tb_top;
   logic                    clk, sys_rst;
   logic [11:0]             awaddr, araddr;
   logic                    awvalid, awready, wvalid, wready, bvalid, bready;
   logic                    arvalid, arready, rvalid, rready;
   logic [31:0]             wdata, rdata, rd;
   logic [3:0]              wstrb;
   logic [3:0]              ws = 4'hf;
   logic [1:0]              bresp, rresp, rs;
   bcem_pkg::bcem_straps_t  strap_pins;
   bcem_pkg::bcem_irq_src_t irq_src;
   bcem_pkg::bcem_dma_src_t dma_src;
   bcem_pkg::bcem_irq_out_t cpu_irq_controller_in;
   bcem_pkg::bcem_dma_out_t dma_controller_evt;
   bcem_pkg::bcem_boot_src_t boot_mode;
   logic                    bus8, wide;
   logic [1:0]              sapin;
   int                      mismatches, check_count;
   logic [31:0]             vals [3] = '{32'hffffffff, 32'h000000aa, 32'h00000055};

   bcem_regs dut_u (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .strap_pins(strap_pins),
      .irq_src(irq_src), .dma_src(dma_src), .cpu_irq_controller_in(cpu_irq_controller_in),
      .dma_controller_evt(dma_controller_evt), .boot_mode(boot_mode), .async_mem_bus_8bit(bus8),
      .shared_addr_pin_func(sapin), .async_mem_addr_wide(wide));
   bcem_src_model src_u (.clk(clk), .sys_rst(sys_rst), .irq_src(irq_src), .dma_src(dma_src));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // bready held from the start: the response may come right after both beats
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      awaddr <= a; wdata <= d; wstrb <= ws;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask

   function automatic logic [7:0] exp_irq(input logic [7:0] s, input bcem_pkg::bcem_irq_src_t q);
      exp_irq = {q.irq_in_25[s[6]], q.irq_in_24[s[5]], s[7] ? 1'b0 : q.irq_in_20, q.irq_in_19[s[4]],
                 q.irq_in_18[s[3]], q.irq_in_17[s[2]], q.irq_in_14[s[1]], q.irq_in_13[s[0]]};
   endfunction

   function automatic logic [2:0] exp_dma(input logic [2:0] s, input bcem_pkg::bcem_dma_src_t q);
      exp_dma = {s[2] ? 1'b0 : q.evt_26, q.evt_9[s[1]], q.evt_8[s[0]]};
   endfunction

   // output at one falling edge is the selected source seen at the falling edge before
   task automatic check_mux(input logic [7:0] is, input logic [2:0] ds);
      bcem_pkg::bcem_irq_src_t ir;
      bcem_pkg::bcem_dma_src_t dr;
      @(negedge clk);
      ir = irq_src;
      dr = dma_src;
      repeat (6) begin
         @(negedge clk);
         check({24'h0, cpu_irq_controller_in}, {24'h0, exp_irq(is, ir)});
         check({29'h0, dma_controller_evt}, {29'h0, exp_dma(ds, dr)});
         ir = irq_src;
         dr = dma_src;
      end
   endtask

   task automatic check_boot(input logic [31:0] v, input logic [1:0] m, input logic b8,
                             input logic [1:0] sa, input logic aw);
      axi_read(`BCEM_OFF_BOOT, rd, rs);
      check(rd, v);
      check({30'h0, rs}, {30'h0, `BCEM_RESP_OKAY});
      check({30'h0, boot_mode}, {30'h0, m});
      check({31'h0, bus8}, {31'h0, b8});
      check({30'h0, sapin}, {30'h0, sa});
      check({31'h0, wide}, {31'h0, aw});
      axi_read(`BCEM_OFF_IRQ_SEL, rd, rs);
      check(rd, 32'h00000000);
      axi_read(`BCEM_OFF_DMA_SEL, rd, rs);
      check(rd, 32'h00000000);
   endtask

   initial begin
      sys_rst = 1'b1;
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      strap_pins = bcem_pkg::bcem_straps_t'(7'h4d); // nand boot with 8-bit bus straps
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (6) @(posedge clk);
      check_boot(32'h0000010d, 2'h0, 1'b1, 2'h2, 1'b1);
      check_mux(8'h00, 3'h0);
      for (int i = 0; i < 3; i++) begin
         axi_write(`BCEM_OFF_IRQ_SEL, vals[i], rs);
         check({30'h0, rs}, {30'h0, `BCEM_RESP_OKAY});
         axi_write(`BCEM_OFF_DMA_SEL, vals[i], rs);
         axi_read(`BCEM_OFF_IRQ_SEL, rd, rs);
         check(rd, {24'h0, vals[i][7:0]});
         axi_read(`BCEM_OFF_DMA_SEL, rd, rs);
         check(rd, {29'h0, vals[i][2:0]});
         check_mux(vals[i][7:0], vals[i][2:0]);
      end
      axi_write(`BCEM_OFF_BOOT, 32'hffffffff, rs);
      check({30'h0, rs}, {30'h0, `BCEM_RESP_OKAY});
      axi_read(`BCEM_OFF_BOOT, rd, rs);
      check(rd, 32'h0000010d);
      // byte lane 0 off: the select bits must hold their last value
      ws = 4'he;
      axi_write(`BCEM_OFF_IRQ_SEL, 32'h00000000, rs);
      ws = 4'hf;
      axi_read(`BCEM_OFF_IRQ_SEL, rd, rs);
      check(rd, {24'h0, vals[2][7:0]});
      axi_write(12'h00c, 32'hffffffff, rs);
      check({30'h0, rs}, {30'h0, `BCEM_RESP_SLVERR});
      axi_read(12'h00c, rd, rs);
      check(rd, 32'h00000000);
      check({30'h0, rs}, {30'h0, `BCEM_RESP_SLVERR});
      // second reset mid-run with new straps: capture must follow, selects clear
      @(posedge clk);
      sys_rst <= 1'b1;
      strap_pins <= bcem_pkg::bcem_straps_t'(7'h12); // async memory boot with 16-bit bus straps
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (6) @(posedge clk);
      check_boot(32'h00000042, 2'h1, 1'b0, 2'h1, 1'b0);
      check_mux(8'h00, 3'h0);
      end_of_test();
   end

   // the whole sequence needs well under a thousand cycles; this only cuts a hang
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      end_of_test();
   end
endmodule
